// ==== core/pci_config_space_regs.sv ====
// Configuration-space register bank of a PCI target/master core.
// Assumes the host port decodes configuration cycles into word strobes;
// event inputs are single-cycle pulses from logic on CLK.
// Notes on behaviour
// - Command bits 0,1 gate I/O, memory decode
// - Command bit 2 gates mastering; zero target-only
// - Bit 6 parity response, bit 8 SERR driver
// - Bit 10 blocks INTA; status 3 shows INTA
// - Unsupported command bits read zero
// - Fixed status bits: capability, 66 MHz, slow devsel
// - Status 8 sets on master PERR, W1C
// - Status 11 sets on target abort, W1C
// - Status 12,13 master aborts, W1C, target-only zero
// - Status 14 sets on SERR assertion, W1C
// - Status 15 sets on any parity error, W1C
// - Memory BAR low bits fixed, width-masked base
// - I/O BAR reads bit 0 one, width-masked
// - ROM BAR enable parameter, width-masked base
// - Capability pointer 44 or master 48/4C
// - Interrupt line byte plain storage, pin 01
// - Hot-swap ID 06, mask holds enumeration off
// - Insert/extract flags W1C, pending is OR
// - Vendor capability fixed ID, size, DMA location
// - Flush bit pulses FIFO flush, reads zero
// - External interrupt flag gated by enable bit
// - FIFO status nibbles per BAR
// - Unimplemented locations read zero
`timescale 1ns/1ps
`include "cfg_regs_cfg.svh"
module pci_config_space_regs
   import cfg_regs_pkg::*;
#(
   parameter bit HAS_MASTER = 1'b1,
   parameter bit HAS_HOTSWAP = 1'b1,
   parameter bit HAS_FIFO_RECOVERY = 1'b1,
   parameter bit HAS_FIFO_STATUS = 1'b1,
   parameter bit fast_bus_capable_param = 1'b0,
   parameter logic [5:0] BAR_IS_IO = 6'b000010,
   parameter logic [5:0] window_prefetchable_param = 6'b000000,
   parameter int window_size_bits_param [6] = '{17, 8, 12, 12, 12, 12},
   parameter logic [5:0] BAR_PRESENT = 6'b000011,
   parameter bit rom_window_on_param = 1'b1,
   parameter int rom_window_size_param = 16,
   parameter logic [7:0] CAP_SIZE = 8'd12,
   parameter logic [1:0] dma_window_placement = DMA_ABSENT,
   parameter logic [2:0] DMA_BAR_SEL = 3'h0,
   parameter bit BACKEND_DMA = 1'b0,
   parameter bit window_overflow_off = 1'b0,
   parameter bit wait_limit_timer_off = 1'b0
)(
   input wire logic CLK, // 10 MHz bus clock
   input wire logic ARST_N, // Asynchronous reset, active low
   input wire logic CFG_RD, // Configuration read strobe
   input wire logic CFG_WR, // Configuration write strobe
   input wire logic [7:0] CFG_ADDR, // Dword byte address
   input wire logic [3:0] CFG_BE, // Byte enables, active high
   input wire logic [31:0] CFG_WDATA, // Write data
   input wire logic INT_REQ, // Internal interrupt request
   input wire logic EV_MASTER_PERR, // Master saw PERRn
   input wire logic EV_TARGET_ABORT, // Target signalled abort
   input wire logic EV_RX_TARGET_ABORT, // Master got target abort
   input wire logic EV_MASTER_ABORT, // Master did master abort
   input wire logic EV_SERR, // Target asserted SERRn
   input wire logic EV_PARITY, // Any parity error detected
   input wire logic EV_INSERT, // Board inserted
   input wire logic EV_EXTRACT, // Extraction requested
   input wire logic user_side_irq_in_N, // User interrupt pin
   input wire logic [23:0] FIFO_LEVELS, // Queue and ext flags
   output logic [31:0] CFG_RDATA, // Read data
   output logic CFG_RVALID, // Read data valid
   output logic IO_DECODE_EN, // I/O space enabled
   output logic MEM_DECODE_EN, // Memory space enabled
   output logic MASTER_EN, // Mastering allowed
   output logic PARITY_RESP_EN, // Parity response on
   output logic SERR_DRV_EN, // SERRn driver enabled
   output logic INTA_N, // Interrupt output pin
   output logic enumeration_request_out_N, // Enumeration pin
   output logic indicator_lamp_bit, // Hot-swap lamp
   output logic FIFO_FLUSH, // One-cycle flush pulse
   output logic [191:0] BAR_BASES // Base address words
);
   // -----------------------------------------------------------------
   // Reset release, pin synchroniser and helpers
   // -----------------------------------------------------------------
   logic [1:0] rst_sync_ff;
   logic rst_n;
   logic [1:0] irq_sync_ff;
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         rst_sync_ff <= 2'b00;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_ff[1];

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         irq_sync_ff <= 2'b11;
      end else begin
         irq_sync_ff <= {irq_sync_ff[0], user_side_irq_in_N};
      end
   end

   function automatic word_t bemask(input logic [3:0] be);
      bemask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   endfunction
   function automatic word_t hi_mask(input int w);
      hi_mask = 32'hffff_ffff << w;
   endfunction

   logic wr_hit_cs, wr_hit_hs, wr_hit_ic, wr_hit_il, wr_hit_rom;
   word_t wmask, w1c;
   assign wr_hit_cs = CFG_WR && CFG_ADDR == `OFS_CMD_STAT;
   assign wr_hit_hs = CFG_WR && CFG_ADDR == `OFS_HOTSWAP && HAS_HOTSWAP;
   assign wr_hit_ic = CFG_WR && CFG_ADDR == `OFS_INTCTL;
   assign wr_hit_il = CFG_WR && CFG_ADDR == `OFS_INTLINE;
   assign wr_hit_rom = CFG_WR && CFG_ADDR == `OFS_ROM;
   assign wmask = bemask(CFG_BE);
   assign w1c = CFG_WDATA & wmask;

   // -----------------------------------------------------------------
   // Command and status registers; sticky set wins over clear
   // -----------------------------------------------------------------
   logic io_en_ff, mem_en_ff, mst_en_ff, perr_en_ff, serr_en_ff;
   logic int_dis_ff;
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         io_en_ff <= 1'b0;
         mem_en_ff <= 1'b0;
         mst_en_ff <= 1'b0;
         perr_en_ff <= 1'b0;
         serr_en_ff <= 1'b0;
         int_dis_ff <= 1'b0;
      end else if (wr_hit_cs) begin
         if (CFG_BE[0]) begin
            io_en_ff <= CFG_WDATA[`CMD_IO];
            mem_en_ff <= CFG_WDATA[`CMD_MEM];
            mst_en_ff <= CFG_WDATA[`CMD_MASTER] & HAS_MASTER;
            perr_en_ff <= CFG_WDATA[`CMD_PERR];
         end
         if (CFG_BE[1]) begin
            serr_en_ff <= CFG_WDATA[`CMD_SERR];
            int_dis_ff <= CFG_WDATA[`CMD_INTDIS];
         end
      end
   end

   logic dperr_ff, sta_ff, rta_ff, rma_ff, sse_ff, dpe_ff;
   word_t cs_clr;
   assign cs_clr = wr_hit_cs ? w1c : 32'h0000_0000;
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         dperr_ff <= 1'b0;
         sta_ff <= 1'b0;
         rta_ff <= 1'b0;
         rma_ff <= 1'b0;
         sse_ff <= 1'b0;
         dpe_ff <= 1'b0;
      end else begin
         dperr_ff <= HAS_MASTER & (EV_MASTER_PERR
            | (dperr_ff & ~cs_clr[16 + `ST_DPERR]));
         sta_ff <= EV_TARGET_ABORT
            | (sta_ff & ~cs_clr[16 + `ST_STA]);
         rta_ff <= HAS_MASTER & (EV_RX_TARGET_ABORT
            | (rta_ff & ~cs_clr[16 + `ST_RTA]));
         rma_ff <= HAS_MASTER & (EV_MASTER_ABORT
            | (rma_ff & ~cs_clr[16 + `ST_RMA]));
         sse_ff <= EV_SERR | (sse_ff & ~cs_clr[16 + `ST_SSE]);
         dpe_ff <= EV_PARITY | (dpe_ff & ~cs_clr[16 + `ST_DPE]);
      end
   end

   // -----------------------------------------------------------------
   // Interrupt line, hot-swap, interrupt control
   // -----------------------------------------------------------------
   logic [7:0] int_line_ff;
   logic hs_mask_ff, hs_lamp_ff, hs_ins_ff, hs_ext_ff;
   logic ext_en_ff, ext_st_ff, flush_ff;
   word_t hs_clr, ic_clr;
   assign hs_clr = wr_hit_hs ? w1c : 32'h0000_0000;
   assign ic_clr = wr_hit_ic ? w1c : 32'h0000_0000;
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         int_line_ff <= 8'h00;
      end else if (wr_hit_il && CFG_BE[0]) begin
         int_line_ff <= CFG_WDATA[7:0];
      end
   end
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         hs_mask_ff <= 1'b0;
         hs_lamp_ff <= 1'b0;
         hs_ins_ff <= 1'b0;
         hs_ext_ff <= 1'b0;
      end else begin
         if (wr_hit_hs && CFG_BE[2]) begin
            hs_mask_ff <= CFG_WDATA[`HS_MASK];
            hs_lamp_ff <= CFG_WDATA[`HS_LAMP];
         end
         hs_ins_ff <= HAS_HOTSWAP & (EV_INSERT
            | (hs_ins_ff & ~hs_clr[`HS_INS]));
         hs_ext_ff <= HAS_HOTSWAP & (EV_EXTRACT
            | (hs_ext_ff & ~hs_clr[`HS_EXT]));
      end
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         ext_en_ff <= 1'b0;
         ext_st_ff <= 1'b0;
         flush_ff <= 1'b0;
      end else begin
         if (wr_hit_ic && CFG_BE[1]) begin
            ext_en_ff <= CFG_WDATA[`IC_EXTEN];
         end
         ext_st_ff <= (ext_en_ff & ~irq_sync_ff[1])
            | (ext_st_ff & ~ic_clr[`IC_EXTST]);
         flush_ff <= HAS_FIFO_RECOVERY & ic_clr[`IC_FLUSH];
      end
   end

   // -----------------------------------------------------------------
   // Base address registers
   // -----------------------------------------------------------------
   word_t bar_fix [6];
   word_t bar_wm [6];
   word_t bar_shadow_ff [6];
   word_t rom_wm, rom_fix, rom_base_ff, bar_wdata, bar_old;
   logic bar_wr;
   logic [2:0] bar_widx;
   always_comb begin
      for (int i = 0; i < 6; i++) begin
         if (!BAR_PRESENT[i]) begin
            bar_wm[i] = 32'h0000_0000;
            bar_fix[i] = 32'h0000_0000;
         end else if (BAR_IS_IO[i]) begin
            bar_wm[i] = hi_mask(window_size_bits_param[i])
               & 32'hffff_fffc;
            bar_fix[i] = 32'h0000_0001;
         end else begin
            bar_wm[i] = hi_mask(window_size_bits_param[i])
               & 32'hffff_fff0;
            bar_fix[i] = {28'h0000000,
               window_prefetchable_param[i], 3'h0};
         end
      end
   end
   assign rom_wm = hi_mask(rom_window_size_param)
      & 32'hffff_f800;
   assign rom_fix = {31'h00000000, rom_window_on_param};

   assign bar_widx = 3'((CFG_ADDR - `OFS_BAR0) >> 2);
   assign bar_wr = CFG_WR && CFG_ADDR >= `OFS_BAR0
      && CFG_ADDR <= `OFS_BAR5;
   assign bar_old = bar_shadow_ff[bar_wr ? bar_widx : 3'h0];
   assign bar_wdata = ((bar_old & ~wmask) | (CFG_WDATA & wmask))
      & bar_wm[bar_wr ? bar_widx : 3'h0];
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 6; i++) begin
            bar_shadow_ff[i] <= 32'h0000_0000;
         end
      end else if (bar_wr) begin
         bar_shadow_ff[bar_widx] <= bar_wdata;
      end
   end

   bar_slot_mem u_bars (
      .clk(CLK),
      .rst_n(rst_n),
      .wr_en(bar_wr),
      .wr_idx(bar_widx),
      .wr_data(bar_wdata),
      .rd_idx(bar_widx),
      .rd_data()
   );
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         rom_base_ff <= 32'h0000_0000;
      end else if (wr_hit_rom) begin
         rom_base_ff <= ((rom_base_ff & ~wmask) | (CFG_WDATA & wmask))
            & rom_wm;
      end
   end

   // -----------------------------------------------------------------
   // Read path, one cycle after the strobe, and control outputs
   // -----------------------------------------------------------------
   word_t rd_mux;
   logic [7:0] capptr;
   logic [15:0] cmd_v, stat_v;
   assign capptr = HAS_MASTER ?
      (HAS_FIFO_STATUS ? `CAPPTR_TARG + 8'h04 : `CAPPTR_MAST)
      : `CAPPTR_TARG;
   assign cmd_v = {5'h00, int_dis_ff, 1'b0, serr_en_ff, 1'b0,
      perr_en_ff, 3'h0, mst_en_ff, mem_en_ff, io_en_ff};
   assign stat_v = {dpe_ff, sse_ff, rma_ff, rta_ff, sta_ff,
      `ST_DEVSEL_SLOW, dperr_ff, 2'b00, fast_bus_capable_param,
      1'b1, ~INTA_N, 3'h0};
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (CFG_ADDR)
         `OFS_CMD_STAT: rd_mux = {stat_v, cmd_v};
         `OFS_BAR0, `OFS_BAR1, `OFS_BAR2, `OFS_BAR3, `OFS_BAR4, `OFS_BAR5:
            rd_mux = bar_shadow_ff[bar_widx] | bar_fix[bar_widx];
         `OFS_ROM: rd_mux = rom_base_ff | rom_fix;
         `OFS_CAPPTR: rd_mux = {24'h000000, capptr};
         `OFS_INTLINE: rd_mux = {16'h0000, `INT_PIN_A,
            int_line_ff};
         `OFS_HOTSWAP: if (HAS_HOTSWAP) begin
            rd_mux = {8'h00, hs_ins_ff, hs_ext_ff, 2'b00, hs_lamp_ff,
               hs_ins_ff | hs_ext_ff, hs_mask_ff, 1'b0,
               `HS_NEXT, `HS_CAP_ID};
         end
         `OFS_VENDCAP: rd_mux = {wait_limit_timer_off,
            window_overflow_off, BACKEND_DMA, DMA_BAR_SEL,
            dma_window_placement, CAP_SIZE,
            HAS_HOTSWAP ? `VC_NEXT : 8'h00, `VC_ID};
         `OFS_INTCTL: rd_mux = {16'h0000, ext_en_ff, ext_st_ff,
            14'h0000};
         `OFS_FIFOSTAT: if (HAS_FIFO_STATUS) begin
            rd_mux = {8'h00, FIFO_LEVELS};
         end
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         CFG_RDATA <= 32'h0000_0000;
         CFG_RVALID <= 1'b0;
      end else begin
         CFG_RVALID <= CFG_RD;
         CFG_RDATA <= CFG_RD ? rd_mux : 32'h0000_0000;
      end
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         IO_DECODE_EN <= 1'b0;
         MEM_DECODE_EN <= 1'b0;
         MASTER_EN <= 1'b0;
         PARITY_RESP_EN <= 1'b0;
         SERR_DRV_EN <= 1'b0;
         INTA_N <= 1'b1;
         enumeration_request_out_N <= 1'b1;
         indicator_lamp_bit <= 1'b0;
         FIFO_FLUSH <= 1'b0;
         BAR_BASES <= '0;
      end else begin
         IO_DECODE_EN <= io_en_ff;
         MEM_DECODE_EN <= mem_en_ff;
         MASTER_EN <= mst_en_ff & HAS_MASTER;
         PARITY_RESP_EN <= perr_en_ff;
         SERR_DRV_EN <= serr_en_ff;
         INTA_N <= ~((INT_REQ | ext_st_ff) & ~int_dis_ff);
         enumeration_request_out_N <= ~((hs_ins_ff | hs_ext_ff)
            & ~hs_mask_ff);
         indicator_lamp_bit <= hs_lamp_ff;
         FIFO_FLUSH <= flush_ff;
         for (int i = 0; i < 6; i++) begin
            BAR_BASES[i*32 +: 32] <= bar_shadow_ff[i] | bar_fix[i];
         end
      end
   end
endmodule

// ==== core/cfg_regs_cfg.svh ====
// Constants for the configuration-space register bank.
// Included by the register bank module file; definitions only.
`ifndef CFG_REGS_CFG_SVH
`define CFG_REGS_CFG_SVH

// Word offsets (byte addresses of dwords)
`define OFS_CMD_STAT 8'h04
`define OFS_BAR0 8'h10
`define OFS_BAR1 8'h14
`define OFS_BAR2 8'h18
`define OFS_BAR3 8'h1c
`define OFS_BAR4 8'h20
`define OFS_BAR5 8'h24
`define OFS_ROM 8'h30
`define OFS_CAPPTR 8'h34
`define OFS_INTLINE 8'h3c
`define OFS_HOTSWAP 8'h40
`define OFS_VENDCAP 8'h44
`define OFS_INTCTL 8'h48
`define OFS_FIFOSTAT 8'h4c

// Command bit positions
`define CMD_IO 0
`define CMD_MEM 1
`define CMD_MASTER 2
`define CMD_PERR 6
`define CMD_SERR 8
`define CMD_INTDIS 10

// Status bit positions
`define ST_INT 3
`define ST_CAP 4
`define ST_66 5
`define ST_DPERR 8
`define ST_STA 11
`define ST_RTA 12
`define ST_RMA 13
`define ST_SSE 14
`define ST_DPE 15
`define ST_DEVSEL_SLOW 2'b10

// Fixed field values
`define CAPPTR_TARG 8'h44
`define CAPPTR_MAST 8'h4c
`define INT_PIN_A 8'h01
`define HS_CAP_ID 8'h06
`define HS_NEXT 8'h00
`define VC_ID 8'h09
`define VC_NEXT 8'h40

// Hot-swap bit positions
`define HS_MASK 17
`define HS_PEND 18
`define HS_LAMP 19
`define HS_EXT 22
`define HS_INS 23

// Interrupt control bit positions
`define IC_FLUSH 10
`define IC_EXTST 14
`define IC_EXTEN 15

`endif

// ==== core/cfg_regs_pkg.sv ====
// Types shared by the configuration register bank.
// Assumes the constants header is available.
package cfg_regs_pkg;
   typedef enum logic [1:0] {
      DMA_ABSENT = 2'h0,
      DMA_CFG = 2'h1,
      DMA_MEMBAR = 2'h2,
      DMA_IOBAR = 2'h3
   } dma_loc_e;
   typedef logic [31:0] word_t;
endpackage

// ==== core/bar_slot_mem.sv ====
// Small register memory holding the six base address words.
// Assumes one clock, reset released synchronously by the parent.
`timescale 1ns/1ps
module bar_slot_mem
   import cfg_regs_pkg::*;
(
   input wire logic clk, // Clock
   input wire logic rst_n, // Synchronised reset
   input wire logic wr_en, // Write strobe
   input wire logic [2:0] wr_idx, // Write slot
   input wire word_t wr_data, // Write data, already masked
   input wire logic [2:0] rd_idx, // Read slot
   output word_t rd_data // Registered read data
);
   word_t mem_ff [6];

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 6; i++) begin
            mem_ff[i] <= 32'h0000_0000;
         end
      end else if (wr_en && wr_idx < 3'h6) begin
         mem_ff[wr_idx] <= wr_data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data <= 32'h0000_0000;
      end else begin
         rd_data <= (rd_idx < 3'h6) ? mem_ff[rd_idx] : 32'h0000_0000;
      end
   end
endmodule

// ==== tb/cfg_regs_monitor.sv ====
// Port checker for the configuration register bank.
// Bound into every instance; default parameters assumed.
`timescale 1ns/1ps
module cfg_regs_monitor (
   input wire logic CLK, // Clock
   input wire logic ARST_N, // Reset
   input wire logic CFG_RD, // Read
   input wire logic CFG_WR, // Write
   input wire logic [7:0] CFG_ADDR, // Address
   input wire logic [3:0] CFG_BE, // Lanes
   input wire logic [31:0] CFG_WDATA, // Wdata
   input wire logic EV_TARGET_ABORT, // Abort
   input wire logic [31:0] CFG_RDATA, // Rdata
   input wire logic CFG_RVALID, // Valid
   input wire logic IO_DECODE_EN, // Cmd 0
   input wire logic MEM_DECODE_EN, // Cmd 1
   input wire logic MASTER_EN, // Cmd 2
   input wire logic PARITY_RESP_EN, // Cmd 6
   input wire logic SERR_DRV_EN, // Cmd 8
   input wire logic INTA_N, // Irq
   input wire logic enumeration_request_out_N, // Enum
   input wire logic FIFO_FLUSH // Flush
);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking @(posedge CLK); endclocking
   default disable iff (!ARST_N);
   logic rd_cmd, wr_cmd, rd_hs;
   assign rd_cmd = CFG_RD && CFG_ADDR == 8'h04;
   assign wr_cmd = CFG_WR && CFG_ADDR == 8'h04;
   assign rd_hs = CFG_RD && CFG_ADDR == 8'h40;
   a_decode_follows: assert property (wr_cmd && CFG_BE[0] |-> ##2
      {MEM_DECODE_EN, IO_DECODE_EN} == $past(CFG_WDATA[1:0], 2))
      else $error("decode enables wrong");
   a_master_gate: assert property (wr_cmd && CFG_BE[0] |-> ##2
      MASTER_EN == $past(CFG_WDATA[2], 2)) else $error("master enable wrong");
   a_parity_serr: assert property (wr_cmd && CFG_BE == 4'h3 |-> ##2
      PARITY_RESP_EN == $past(CFG_WDATA[6], 2) &&
      SERR_DRV_EN == $past(CFG_WDATA[8], 2)) else $error("parity or serr wrong");
   a_intdis_holds: assert property (wr_cmd && CFG_BE[1] && CFG_WDATA[10]
      |-> ##3 INTA_N) else $error("interrupt not blocked");
   a_int_status: assert property (rd_cmd ##1 $stable(INTA_N) |->
      CFG_RDATA[19] == !INTA_N) else $error("interrupt status wrong");
   a_cmd_ro_zero: assert property (rd_cmd |=> CFG_RVALID &&
      CFG_RDATA[15:11] == 5'h0 && CFG_RDATA[9] == 1'b0 &&
      CFG_RDATA[7] == 1'b0 && CFG_RDATA[5:3] == 3'h0)
      else $error("read-only command bits set");
   a_status_fixed: assert property (rd_cmd |=> CFG_RDATA[26:25] == 2'h2 &&
      CFG_RDATA[23:20] == 4'h1 && CFG_RDATA[18:16] == 3'h0)
      else $error("fixed status bits wrong");
   a_abort_sticky: assert property (EV_TARGET_ABORT ##2 rd_cmd |=>
      CFG_RDATA[27]) else $error("target abort flag lost");
   a_pending_or: assert property (rd_hs |=> CFG_RDATA[15:0] == 16'h0006 &&
      CFG_RDATA[18] == (CFG_RDATA[22] || CFG_RDATA[23]))
      else $error("hot-swap word wrong");
   a_enum_masked: assert property (rd_hs ##1 CFG_RDATA[17] |->
      enumeration_request_out_N) else $error("enumeration not masked");
   a_flush_pulse: assert property (CFG_WR && CFG_ADDR == 8'h48 &&
      CFG_BE[1] && CFG_WDATA[10] |-> ##2 FIFO_FLUSH ##1 !FIFO_FLUSH)
      else $error("flush pulse wrong");
   a_unmapped_zero: assert property (CFG_RD && CFG_ADDR == 8'h08 |=>
      CFG_RVALID && CFG_RDATA == 32'h0) else $error("unmapped read nonzero");
   c_flush: cover property (FIFO_FLUSH);
   c_enum: cover property (!enumeration_request_out_N);
   c_intdis: cover property (rd_cmd ##1 CFG_RDATA[10]);
endmodule
bind pci_config_space_regs cfg_regs_monitor mon_i (.*);

// ==== tb/cfg_host_model.sv ====
// Host issuing configuration reads and writes.
// Accepts a read answered up to four cycles after it is taken.
`timescale 1ns/1ps
module cfg_host_model (
   input wire logic CLK, // Clock
   output logic CFG_RD, // Read strobe
   output logic CFG_WR, // Write strobe
   output logic [7:0] CFG_ADDR, // Address
   output logic [3:0] CFG_BE, // Lanes
   output logic [31:0] CFG_WDATA, // Write data
   input wire logic [31:0] CFG_RDATA, // Read data
   input wire logic CFG_RVALID // Read valid
);
   initial begin
      CFG_RD = 1'b0;
      CFG_WR = 1'b0;
      CFG_ADDR = 8'h0;
      CFG_BE = 4'h0;
      CFG_WDATA = 32'h0;
   end
   task automatic req(input logic rd, input logic [7:0] a,
      input logic [3:0] be, input logic [31:0] d);
      @(posedge CLK);
      CFG_RD <= rd;
      CFG_WR <= !rd;
      CFG_ADDR <= a;
      CFG_BE <= be;
      CFG_WDATA <= d;
      @(posedge CLK);
      CFG_RD <= 1'b0;
      CFG_WR <= 1'b0;
      CFG_ADDR <= ~a; // Idle lines never echo the last cycle
      CFG_BE <= ~be;
      CFG_WDATA <= ~d;
   endtask
   task automatic wr(input logic [7:0] a, input logic [3:0] be,
      input logic [31:0] d);
      req(1'b0, a, be, d);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] q,
      output bit ok);
      req(1'b1, a, 4'hf, 32'h0);
      ok = 1'b0;
      q = 32'hx;
      for (int i = 0; i < 4 && !ok; i++) begin
         @(posedge CLK);
         if (CFG_RVALID === 1'b1) begin
            ok = 1'b1;
            q = CFG_RDATA;
         end
      end
   endtask
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the configuration register bank.
// Drives the host model plus event and level inputs.
`timescale 1ns/1ps
module testbench;
   logic CLK, ARST_N, INT_REQ, user_side_irq_in_N;
   logic [7:0] ev;
   logic [23:0] FIFO_LEVELS;
   wire logic CFG_RD, CFG_WR, CFG_RVALID, IO_DECODE_EN, MEM_DECODE_EN;
   wire logic MASTER_EN, PARITY_RESP_EN, SERR_DRV_EN, INTA_N;
   wire logic enumeration_request_out_N, indicator_lamp_bit, FIFO_FLUSH;
   wire logic EV_MASTER_PERR, EV_TARGET_ABORT, EV_RX_TARGET_ABORT;
   wire logic EV_MASTER_ABORT, EV_SERR, EV_PARITY, EV_INSERT, EV_EXTRACT;
   wire logic [7:0] CFG_ADDR;
   wire logic [3:0] CFG_BE;
   wire logic [31:0] CFG_WDATA, CFG_RDATA;
   wire logic [191:0] BAR_BASES;
   int fail_count, n_checks;
   logic [5:0] acc, m;
   logic [31:0] r;
   logic [7:0] ad [8] = '{8'h10, 8'h14, 8'h18, 8'h30, 8'h08, 8'h34, 8'h3c,
      8'h44};
   logic [31:0] ex [8] = '{32'hfffe_0000, 32'hffff_ff01, 32'h0,
      32'hffff_0001, 32'h0, 32'h48, 32'h1ff, 32'h000c_4009};
   assign {EV_EXTRACT, EV_INSERT, EV_PARITY, EV_SERR, EV_MASTER_ABORT,
      EV_RX_TARGET_ABORT, EV_TARGET_ABORT, EV_MASTER_PERR} = ev;
   pci_config_space_regs pci_config_space_regs_i (.*);
   cfg_host_model host_i (.*);
   always #50 CLK = ~CLK;
   // Status word for a set of sticky flags
   function automatic logic [15:0] st(input logic [5:0] f);
      st = {f[5:1], 2'b10, f[0], 8'h10};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic test_done();
      $display("checks=%0d mismatches=%0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bit ok;
      host_i.rd(a, q, ok);
      if (!ok) begin
         fail_count++;
         test_done();
      end
      chk(q, e);
   endtask
   task automatic pulse(input logic [7:0] p);
      @(posedge CLK);
      ev <= p;
      @(posedge CLK);
      ev <= 8'h0;
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge CLK);
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      CLK = 1'b0;
      ARST_N = 1'b0;
      INT_REQ = 1'b0;
      user_side_irq_in_N = 1'b1;
      ev = 8'h0;
      FIFO_LEVELS = 24'h0;
      acc = 6'h0;
      void'($urandom(6));
      wt(20);
      ARST_N <= 1'b1;
      wt(3);
      rdc(8'h04, 32'h0410_0000);
      for (int i = 0; i < 10; i++) begin
         m = (i == 0) ? 6'h3f : 6'($urandom);
         pulse({2'b00, m});
         acc = acc | m;
         rdc(8'h04, {st(acc), 16'h0});
         m = 6'($urandom);
         host_i.wr(8'h04, 4'hc, {st(m) & 16'hf900, 16'h0});
         acc = acc & ~m;
         rdc(8'h04, {st(acc), 16'h0});
      end
      host_i.wr(8'h04, 4'h3, 32'hffff_ffff);
      rdc(8'h04, {st(acc), 16'h0547});
      wt(3);
      chk(32'({MASTER_EN, MEM_DECODE_EN, IO_DECODE_EN}), 32'h7);
      host_i.wr(8'h04, 4'h3, 32'h0);
      INT_REQ <= 1'b1;
      wt(4);
      chk(32'(INTA_N), 32'h0);
      rdc(8'h04, {st(acc) | 16'h0008, 16'h0});
      host_i.wr(8'h04, 4'h2, 32'h0400);
      wt(4);
      chk(32'(INTA_N), 32'h1);
      rdc(8'h04, {st(acc), 16'h0400});
      INT_REQ <= 1'b0;
      host_i.wr(8'h04, 4'h2, 32'h0);
      for (int i = 0; i < 8; i++) begin
         host_i.wr(ad[i], 4'hf, 32'hffff_ffff);
         rdc(ad[i], ex[i]);
      end
      chk(BAR_BASES[63:32], 32'hffff_ff01);
      r = $urandom;
      host_i.wr(8'h10, 4'hf, r);
      rdc(8'h10, r & 32'hfffe_0000);
      chk(BAR_BASES[31:0], r & 32'hfffe_0000);
      pulse(8'h40);
      wt(3);
      chk(32'(enumeration_request_out_N), 32'h0);
      rdc(8'h40, 32'h0084_0006);
      host_i.wr(8'h40, 4'h4, 32'h000a_0000);
      wt(3);
      chk(32'({enumeration_request_out_N, indicator_lamp_bit}), 32'h3);
      rdc(8'h40, 32'h008e_0006);
      host_i.wr(8'h40, 4'h4, 32'h0080_0000);
      rdc(8'h40, 32'h0000_0006);
      pulse(8'h80);
      wt(3);
      chk(32'(enumeration_request_out_N), 32'h0);
      rdc(8'h40, 32'h0044_0006);
      host_i.wr(8'h40, 4'h4, 32'h0040_0000);
      wt(3);
      chk(32'(enumeration_request_out_N), 32'h1);
      host_i.wr(8'h48, 4'h2, 32'h8000);
      user_side_irq_in_N <= 1'b0;
      wt(6);
      chk(32'(INTA_N), 32'h0);
      rdc(8'h48, 32'hc000);
      user_side_irq_in_N <= 1'b1;
      wt(6);
      host_i.wr(8'h48, 4'h2, 32'hc000);
      rdc(8'h48, 32'h8000);
      host_i.wr(8'h48, 4'h2, 32'h0);
      user_side_irq_in_N <= 1'b0;
      wt(6);
      rdc(8'h48, 32'h0);
      user_side_irq_in_N <= 1'b1;
      host_i.wr(8'h48, 4'h2, 32'h0400);
      rdc(8'h48, 32'h0);
      r = $urandom;
      FIFO_LEVELS <= r[23:0];
      rdc(8'h4c, {8'h0, r[23:0]});
      test_done();
   end
endmodule
